/* hw/sbx_pkg.sv */
// Purpose: shared constants and types for the system bus transfer signals
// Assumes: one 50 MHz clock, bus pins synchronous to it
// Notes:   address bit 0 is the most significant bit of a 32-bit address
package sbx_pkg;
   localparam int ADDR_W     = 26;
   localparam int FULL_W     = 32;
   localparam int ADDR_LSB   = 6;
   localparam int SIZE_W     = 2;
   localparam int BEATS_W    = 3;
   localparam logic [25:0] ADDR_RST  = 26'h0000000;
   localparam logic [1:0]  SIZE_RST  = 2'h0;
   localparam logic [2:0]  BEATS_RST = 3'h0;
   localparam logic [2:0]  BEAT_ONE  = 3'h1;
   localparam logic        DIR_READ  = 1'h1;
   localparam logic        DIR_WRITE = 1'h0;

   // gray along idle -> start -> data; data -> idle changes both bits
   typedef enum logic [1:0] {
      SBX_IDLE  = 2'b00,
      SBX_START = 2'b01,
      SBX_DATA  = 2'b11
   } sbx_state_e;
endpackage : sbx_pkg

/* hw/sbx_if.sv */
// Purpose: captured external transaction passed to the sampler's user
// Assumes: single clock
// Notes:   valid is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface sbx_capt_if;
   import sbx_pkg::*;
   logic              valid;
   logic [ADDR_W-1:0] addr;
   logic [SIZE_W-1:0] size;
   logic              read;
   logic              burst;
   modport src (output valid, output addr, output size, output read,
                output burst);
   modport dst (input valid, input addr, input size, input read,
                input burst);
endinterface : sbx_capt_if
`default_nettype wire

/* hw/sbx_sampler.sv */
// Purpose: samples bus lines when an external master starts a cycle
// Assumes: caller only enables it while the device is not bus owner
// Notes:   registered capture, one cycle after the start strobe
`timescale 1ns/1ns
`default_nettype none
module sbx_sampler
   import sbx_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // bus pin inputs
   input  wire logic              enable,
   input  wire logic              start_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [SIZE_W-1:0] size_in,
   input  wire logic              read_in,
   input  wire logic              burst_in,
   // captured transaction
   sbx_capt_if.src                capt
);
   logic              valid_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [SIZE_W-1:0] size_ff;
   logic              read_ff;
   logic              burst_ff;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= enable & start_in; // [R13]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff  <= ADDR_RST;
         size_ff  <= SIZE_RST;
         read_ff  <= 1'b0;
         burst_ff <= 1'b0;
      end else if (enable && start_in) begin
         addr_ff  <= addr_in;  // [R03]
         size_ff  <= size_in;  // [R05] [R06]
         read_ff  <= read_in;  // [R06]
         burst_ff <= burst_in; // [R06]
      end
   end

   assign capt.valid = valid_ff;
   assign capt.addr  = addr_ff;
   assign capt.size  = size_ff;
   assign capt.read  = read_ff;
   assign capt.burst = burst_ff;

   property p_capture_addr;
      @(posedge sys_clk) disable iff (!rstn)
      (enable && start_in) |=> (valid_ff && addr_ff == $past(addr_in));
   endproperty
   a_capture_addr: assert property (p_capture_addr) // [R03]
      else $error("external address not captured");

   property p_no_capture_when_owner;
      @(posedge sys_clk) disable iff (!rstn)
      !enable |=> !valid_ff;
   endproperty
   a_no_capture_when_owner: assert property (p_no_capture_when_owner) // [R13]
      else $error("capture while owning the bus");
endmodule : sbx_sampler
`default_nettype wire

/* hw/sbx_bus.sv */
// Purpose: system bus address, size, direction, burst and start lines
// Assumes: arbitration is outside; bus_owner says when we hold the bus
// Notes:   internal master issues one request per cycle start
//
// Operation
// [R01] address bus is 26 low bits of 32-bit address, bit 0 most significant
// [R02] drive address lines when an internal master starts a transaction
// [R03] sample address lines when an external master starts a transaction
// [R04] two size lines give operand bytes left in the bus cycle
// [R05] sample size line 0 when an external master starts
// [R06] drive size 1, direction, burst when owner; otherwise sample them
// [R07] direction high means read, low means write
// [R08] burst asserted for burst transfers, negated for single beats
// [R09] beat-pending asserted while more beats wanted, negated before last
// [R10] beat-pending pin doubles as machine B general line 5
// [R11] start line marks the beginning of each data bus cycle
// [R12] drive start only when owner; negated before releasing the bus
// [R13] when not owner, sampled start means an external master began
// [R14] start lasts one clock with address, size, direction, burst valid
`timescale 1ns/1ns
`default_nettype none
module sbx_bus
   import sbx_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // ownership
   input  wire logic              bus_owner,
   // internal master request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic [FULL_W-1:0] req_addr,
   input  wire logic [SIZE_W-1:0] req_size,
   input  wire logic              req_read,
   input  wire logic [BEATS_W-1:0] req_beats,
   input  wire logic              beat_done,
   output logic                   xfer_busy,
   // memory controller side
   input  wire logic              programmable_machine_b,
   input  wire logic              upm_b_general_line5,
   output logic                   ext_valid,
   output logic [ADDR_W-1:0]      ext_addr,
   output logic [SIZE_W-1:0]      ext_size,
   output logic                   ext_read,
   output logic                   ext_burst,
   // address pins
   input  wire logic [ADDR_W-1:0] addr_i,
   output logic [ADDR_W-1:0]      addr_o,
   output logic                   addr_oe,
   // size, direction, burst pins
   input  wire logic [SIZE_W-1:0] xfer_size_i,
   output logic [SIZE_W-1:0]      xfer_size_o,
   output logic                   xfer_size_oe,
   input  wire logic              read_write_i,
   output logic                   read_write_o,
   output logic                   read_write_oe,
   input  wire logic              burst_i,
   output logic                   burst_o,
   output logic                   burst_oe,
   // beat-pending pin
   output logic                   burst_beat_pending,
   output logic                   burst_beat_pending_oe,
   // start pin
   input  wire logic              xfer_start_i,
   output logic                   xfer_start,
   output logic                   xfer_start_oe
);
   ////////////////////////////////////////////////////////////////////////
   sbx_state_e        state_ff;
   sbx_state_e        nxt_state;
   logic [ADDR_W-1:0] addr_ff;
   logic [SIZE_W-1:0] size_ff;
   logic              read_ff;
   logic              burst_ff;
   logic [BEATS_W-1:0] beats_ff;
   logic              owner_ff;
   sbx_capt_if        capt ();

   // request only accepted while owning the bus
   assign req_ready = bus_owner && (state_ff == SBX_IDLE); // [R12]
   assign xfer_busy = (state_ff != SBX_IDLE);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SBX_IDLE: begin
            if (req_valid && req_ready) begin
               nxt_state = SBX_START;
            end
         end
         SBX_START: begin
            nxt_state = SBX_DATA; // [R14]
         end
         SBX_DATA: begin
            if (beat_done && beats_ff <= BEAT_ONE) begin
               nxt_state = SBX_IDLE;
            end
         end
         default: begin
            nxt_state = SBX_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= SBX_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         owner_ff <= 1'b0;
      end else begin
         owner_ff <= bus_owner;
      end
   end

   // keep the low 26 address bits of the 32-bit address
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff  <= ADDR_RST;
         size_ff  <= SIZE_RST;
         read_ff  <= DIR_WRITE;
         burst_ff <= 1'b0;
      end else if (req_valid && req_ready) begin
         addr_ff  <= req_addr[FULL_W-ADDR_LSB-1:0]; // [R01]
         size_ff  <= req_size;                      // [R04]
         read_ff  <= req_read;                      // [R07]
         burst_ff <= (req_beats > BEAT_ONE);        // [R08]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         beats_ff <= BEATS_RST;
      end else if (req_valid && req_ready) begin
         beats_ff <= req_beats;
      end else if (state_ff == SBX_DATA && beat_done) begin
         beats_ff <= beats_ff - BEAT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address pins driven by us only while owner and our cycle runs; size, direction, burst and start whenever owner
   assign addr_o        = addr_ff;                           // [R02]
   assign addr_oe       = bus_owner && (state_ff != SBX_IDLE); // [R02]
   assign xfer_size_o   = size_ff;
   assign xfer_size_oe  = bus_owner;                         // [R06]
   assign read_write_o  = read_ff;                           // [R07]
   assign read_write_oe = bus_owner;                         // [R06]
   assign burst_o       = burst_ff;                          // [R08]
   assign burst_oe      = bus_owner;                         // [R06]
   assign xfer_start    = (state_ff == SBX_START);           // [R11] [R14]
   assign xfer_start_oe = bus_owner;                         // [R12]

   // beats left > 1 means another beat is wanted; drop before the last
   // pin is shared: machine B owns it when it runs the slave access
   assign burst_beat_pending = programmable_machine_b ? upm_b_general_line5
      : (state_ff == SBX_DATA && burst_ff && beats_ff > BEAT_ONE); // [R09] [R10]
   assign burst_beat_pending_oe = bus_owner || programmable_machine_b;

   ////////////////////////////////////////////////////////////////////////
   sbx_sampler u_sampler (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .enable   (!bus_owner),    // [R13]
      .start_in (xfer_start_i),
      .addr_in  (addr_i),
      .size_in  (xfer_size_i),
      .read_in  (read_write_i),
      .burst_in (burst_i),
      .capt     (capt.src)
   );

   assign ext_valid = capt.valid;
   assign ext_addr  = capt.addr;
   assign ext_size  = capt.size;
   assign ext_read  = capt.read;
   assign ext_burst = capt.burst;

   ////////////////////////////////////////////////////////////////////////
   sequence s_accept;
      req_valid && req_ready;
   endsequence
   sequence s_start_pulse;
      xfer_start ##1 !xfer_start;
   endsequence

   property p_start_one_clock;
      @(posedge sys_clk) disable iff (!rstn)
      s_accept |=> s_start_pulse;
   endproperty
   a_start_one_clock: assert property (p_start_one_clock) // [R14]
      else $error("start not a single clock after accept");

   property p_addr_with_start;
      @(posedge sys_clk) disable iff (!rstn)
      s_accept |=> (addr_o == $past(req_addr[FULL_W-ADDR_LSB-1:0])
                    && addr_oe);
   endproperty
   a_addr_with_start: assert property (p_addr_with_start) // [R01]
      else $error("address not low 26 bits at start");

   property p_dir;
      @(posedge sys_clk) disable iff (!rstn)
      s_accept |=> (read_write_o == $past(req_read));
   endproperty
   a_dir: assert property (p_dir) // [R07]
      else $error("direction line wrong");

   property p_burst;
      @(posedge sys_clk) disable iff (!rstn)
      s_accept |=> (burst_o == ($past(req_beats) > BEAT_ONE));
   endproperty
   a_burst: assert property (p_burst) // [R08]
      else $error("burst line wrong");

   property p_start_only_owner;
      @(posedge sys_clk) disable iff (!rstn)
      xfer_start |-> (xfer_start_oe && bus_owner);
   endproperty
   a_start_only_owner: assert property (p_start_only_owner) // [R12]
      else $error("start driven without ownership");

   property p_pending_last;
      @(posedge sys_clk) disable iff (!rstn)
      (state_ff == SBX_DATA && beats_ff == BEAT_ONE && !programmable_machine_b)
      |-> !burst_beat_pending;
   endproperty
   a_pending_last: assert property (p_pending_last) // [R09]
      else $error("beat pending held on last beat");

   property p_gpl;
      @(posedge sys_clk) disable iff (!rstn)
      programmable_machine_b |-> burst_beat_pending == upm_b_general_line5;
   endproperty
   a_gpl: assert property (p_gpl) // [R10]
      else $error("general line not routed");

   property p_ext_sample;
      @(posedge sys_clk) disable iff (!rstn)
      (!bus_owner && xfer_start_i) |=> (ext_valid
         && ext_size == $past(xfer_size_i) && ext_read == $past(read_write_i));
   endproperty
   a_ext_sample: assert property (p_ext_sample) // [R05] [R06] [R13]
      else $error("external start not sampled");

   property p_release_drive;
      @(posedge sys_clk) disable iff (!rstn)
      !bus_owner |-> !(addr_oe || xfer_size_oe || burst_oe || xfer_start_oe);
   endproperty
   a_release_drive: assert property (p_release_drive) // [R02] [R06]
      else $error("driving pins while not owner");
endmodule : sbx_bus
`default_nettype wire

/* sim/sbx_far_model.sv */
// Purpose: far side of the bus: one external master and one slave
// Assumes: go is raised only while the device does not own the bus
// Notes:   released start stays low; other lines show a changing pattern, not a held value
`timescale 1ns/1ns
`default_nettype none
module sbx_far_model
   import sbx_pkg::*;
(
   // clock and device view
   input  wire logic              sys_clk,
   input  wire logic              bus_owner,
   input  wire logic              start_pin,
   input  wire logic              pending,
   input  wire logic [1:0]        lat,
   // external master command
   input  wire logic              go,
   input  wire logic [ADDR_W-1:0] m_addr,
   input  wire logic [SIZE_W-1:0] m_size,
   input  wire logic              m_read,
   input  wire logic              m_burst,
   // far drive
   output logic [ADDR_W-1:0]      far_addr,
   output logic [SIZE_W-1:0]      far_size,
   output logic                   far_read,
   output logic                   far_burst,
   output logic                   far_start,
   output logic                   beat_done
);
   logic [ADDR_W-1:0] mix  = '0;
   logic              act  = 1'b0;
   logic              last = 1'b0;
   logic              bd   = 1'b0;
   logic [1:0]        wt   = 2'h0;

   always @(posedge sys_clk) mix <= mix + 26'h1;

   // start for one clock, fields valid with it
   assign far_start = go;
   assign far_addr  = go ? m_addr : ~m_addr ^ mix;
   assign far_size  = go ? m_size : mix[1:0];
   assign far_read  = go ? m_read : mix[0];
   assign far_burst = go ? m_burst : ~mix[0];
   assign beat_done = bd;

   ////////////////////////////////////////////////////////////////////////////
   // slave: last beat is the one asked for while pending is low
   always @(posedge sys_clk) begin
      if (start_pin && bus_owner) begin
         act <= 1'b1;
         wt  <= lat;
      end else if (act) begin
         if (bd) begin
            bd <= 1'b0;
            wt <= lat;
            if (last) begin
               act <= 1'b0;
            end
         end else if (wt != 2'h0) begin
            wt <= wt - 2'h1;
         end else begin
            bd   <= 1'b1;
            last <= !pending;
         end
      end
   end
endmodule : sbx_far_model
`default_nettype wire

/* sim/testbench.sv */
// Purpose: self-checking bench for the system bus transfer signals
// Assumes: pin levels resolved here from the device's enables; far side drives otherwise
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import sbx_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, bus_owner = 1'b1;
   logic req_valid = 1'b0, req_read = 1'b0, go = 1'b0;
   logic programmable_machine_b = 1'b0, upm_b_general_line5 = 1'b0;
   logic m_read = 1'b0, m_burst = 1'b0;
   logic [FULL_W-1:0]  req_addr = '0;
   logic [SIZE_W-1:0]  req_size = '0, m_size = '0;
   logic [BEATS_W-1:0] req_beats = '0;
   logic [ADDR_W-1:0]  m_addr = '0, ext_addr, addr_i, addr_o, far_addr;
   logic [SIZE_W-1:0]  ext_size, xfer_size_i, xfer_size_o, far_size;
   logic [1:0]         lat = 2'h0;
   logic req_ready, xfer_busy, ext_valid, ext_read, ext_burst, beat_done;
   logic addr_oe, xfer_size_oe, read_write_i, read_write_o, read_write_oe;
   logic burst_i, burst_o, burst_oe, far_read, far_burst, far_start;
   logic burst_beat_pending, burst_beat_pending_oe;
   logic xfer_start_i, xfer_start, xfer_start_oe;
   int   errors = 0;
   int   compares = 0;

   always #10 sys_clk = ~sys_clk;
   assign addr_i       = addr_oe ? addr_o : far_addr;
   assign xfer_size_i  = xfer_size_oe ? xfer_size_o : far_size;
   assign read_write_i = read_write_oe ? read_write_o : far_read;
   assign burst_i      = burst_oe ? burst_o : far_burst;
   assign xfer_start_i = xfer_start_oe ? xfer_start : far_start;

   sbx_bus uut (.sys_clk, .rstn, .bus_owner, .req_valid, .req_ready,
      .req_addr, .req_size, .req_read, .req_beats, .beat_done, .xfer_busy,
      .programmable_machine_b, .upm_b_general_line5, .ext_valid, .ext_addr,
      .ext_size, .ext_read, .ext_burst, .addr_i, .addr_o, .addr_oe,
      .xfer_size_i, .xfer_size_o, .xfer_size_oe, .read_write_i,
      .read_write_o, .read_write_oe, .burst_i, .burst_o, .burst_oe,
      .burst_beat_pending, .burst_beat_pending_oe, .xfer_start_i,
      .xfer_start, .xfer_start_oe);
   sbx_far_model far (.sys_clk, .bus_owner, .start_pin(xfer_start_i),
      .pending(burst_beat_pending), .lat, .go, .m_addr, .m_size, .m_read,
      .m_burst, .far_addr, .far_size, .far_read, .far_burst, .far_start,
      .beat_done);

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_word

   task automatic chk_bit(input logic g, input logic e);
      chk_word({31'h0, g}, {31'h0, e});
   endtask : chk_bit

   task automatic summarize();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // one own cycle; beats 0 and 1 both mean a single beat
   task automatic own_xfer(input logic [31:0] a, input logic [1:0] sz,
                           input logic rd, input logic [2:0] bt);
      int n;
      int seen;
      int eb;
      n = 0;
      seen = 0;
      eb = (bt > 3'h1) ? int'(bt) : 1;
      {req_addr, req_size, req_read, req_beats} = {a, sz, rd, bt};
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 20) begin
         errors++;
         summarize();
      end
      @(negedge sys_clk);
      req_valid = 1'b0;
      chk_bit(xfer_start, 1'b1);
      chk_bit(xfer_start_oe, 1'b1);
      chk_bit(addr_oe, 1'b1);
      chk_word(32'(addr_o), {6'h0, a[25:0]});
      chk_word(32'(xfer_size_o), 32'(sz));
      chk_bit(read_write_o, rd);
      chk_bit(burst_o, bt > 3'h1);
      @(negedge sys_clk);
      chk_bit(xfer_start, 1'b0);
      chk_bit(ext_valid, 1'b0);
      // sample at the falling edge, away from the edge that launches
      while (xfer_busy === 1'b1 && n < 60) begin
         @(negedge sys_clk);
         n++;
         if (beat_done === 1'b1) begin
            seen++;
            chk_bit(burst_beat_pending, seen < eb);
         end
      end
      if (n >= 60) begin
         errors++;
         summarize();
      end
      chk_word(32'(seen), 32'(eb));
   endtask : own_xfer

   // back to back, every size code, prompt and slow slave
   task automatic t_own_cycles();
      own_xfer(32'hffabcdef, 2'h1, DIR_WRITE, 3'h1);
      lat = 2'h2;
      own_xfer(32'h00000010, 2'h0, DIR_READ, 3'h4);
      lat = 2'h0;
      own_xfer(32'hc0000004, 2'h2, DIR_WRITE, 3'h2);
      own_xfer(32'h03fffffc, 2'h3, DIR_READ, 3'h0);
   endtask : t_own_cycles

   task automatic t_foreign();
      bus_owner = 1'b0;
      req_valid = 1'b1;
      @(negedge sys_clk);
      chk_bit(req_ready, 1'b0);
      chk_word(32'({xfer_size_oe, read_write_oe, burst_oe, addr_oe}),
               32'h0);
      for (int i = 0; i < 2; i++) begin
         m_addr = i ? 26'h155aaaa : 26'h2aa5555;
         {m_size, m_read, m_burst} = i ? 4'h8 : 4'hf;
         go = 1'b1;
         @(negedge sys_clk);
         go = 1'b0;
         chk_bit(ext_valid, 1'b1);
         chk_word(32'(ext_addr), 32'(m_addr));
         chk_word(32'(ext_size), 32'(m_size));
         chk_word(32'({ext_read, ext_burst}), 32'({m_read, m_burst}));
         chk_bit(xfer_start_oe, 1'b0);
         @(negedge sys_clk);
         chk_bit(ext_valid, 1'b0);
      end
      req_valid = 1'b0;
   endtask : t_foreign

   task automatic t_machine_b();
      programmable_machine_b = 1'b1;
      for (int i = 0; i < 2; i++) begin
         upm_b_general_line5 = i[0];
         @(negedge sys_clk);
         chk_bit(burst_beat_pending_oe, 1'b1);
         chk_bit(burst_beat_pending, i[0]);
      end
      programmable_machine_b = 1'b0;
      @(negedge sys_clk);
      chk_bit(burst_beat_pending_oe, 1'b0);
      bus_owner = 1'b1;
      // let ready settle from the new ownership before the next request
      @(negedge sys_clk);
   endtask : t_machine_b

   initial begin
      repeat (16) @(negedge sys_clk);
      chk_bit(xfer_start, 1'b0);
      rstn = 1'b1;
      @(negedge sys_clk);
      t_own_cycles();
      t_foreign();
      t_machine_b();
      own_xfer(32'h12345678, 2'h0, DIR_READ, 3'h1);
      summarize();
   end
endmodule : testbench
`default_nettype wire
